/* cdpo_cfg.svh */
// constants for the compare driven pulse outputs
// assumes inclusion by bare name from package and modules
`ifndef CDPO_CFG_SVH
`define CDPO_CFG_SVH
`define CDPO_PIN_COUNT 8
`define CDPO_REG_WIDTH 16
`define CDPO_CLR_LSB 8
`define CDPO_SET_LSB 0
`define CDPO_REG_ADDR 32'hFFFFF700
`define CDPO_REG_RESET 16'h0000
`define CDPO_CMP_WIDTH 16
`define CDPO_LANE_COUNT 2
`define CDPO_LANE_WIDTH 8
`endif

/* cdpo_pkg.sv */
// types for the compare driven pulse outputs
// assumes cdpo_cfg.svh on the include path
`include "cdpo_cfg.svh"
package cdpo_pkg;
    typedef logic [`CDPO_PIN_COUNT-1:0] cdpo_pins_t;
    typedef logic [`CDPO_REG_WIDTH-1:0] cdpo_reg_t;
    typedef logic [`CDPO_CMP_WIDTH-1:0] cdpo_cnt_t;
endpackage

/* cdpo_if.sv */
// link between the timer end and the pulse driver end
// assumes one system clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface cdpo_if;
    logic rise_match;
    logic fall_match;
    modport device (input rise_match, input fall_match);
    modport timer (output rise_match, output fall_match);
endinterface
`default_nettype wire

/* cdpo_timer.sv */
// timer end: free running base counter and two compare registers
// assumes software loads compares, then starts the counter
`timescale 1ns/1ps
`default_nettype none
`include "cdpo_cfg.svh"
module cdpo_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic rise_wr,
    input wire logic fall_wr,
    input wire cdpo_pkg::cdpo_cnt_t wr_data,
    output cdpo_pkg::cdpo_cnt_t count,
    cdpo_if.timer link
);
    typedef struct packed {
        logic run;
        cdpo_pkg::cdpo_cnt_t cnt;
        cdpo_pkg::cdpo_cnt_t rise_cmp;
        cdpo_pkg::cdpo_cnt_t fall_cmp;
        logic rise;
        logic fall;
    } cdpo_tst_t;
    cdpo_tst_t s, next_s;
    always_comb begin
        next_s = s;
        if (start) begin
            next_s.run = 1'b1;
        end
        if (rise_wr) begin
            next_s.rise_cmp = wr_data;
        end
        if (fall_wr) begin
            next_s.fall_cmp = wr_data;
        end
        // counter wraps only by overflow, never by compare
        if (s.run) begin
            next_s.cnt = s.cnt + 16'h0001;
        end
        next_s.rise = s.run && (s.cnt == s.rise_cmp);
        next_s.fall = s.run && (s.cnt == s.fall_cmp);
        if (!rst_n) begin
            next_s = '0;
        end
    end
    always_ff @(posedge clock) begin
        s <= next_s;
    end
    assign count = s.cnt;
    assign link.rise_match = s.rise;
    assign link.fall_match = s.fall;
endmodule // cdpo_timer
`default_nettype wire

/* cdpo_driver.sv */
// pulse driver end: enable register and eight pulse outputs
// assumes one-cycle match pulses from the timer end
// assumes a write strobe of one cycle per write
// assumes both ends share one clock and one reset
// assumes compare values are loaded by the timer end
// assumes a pin flop may stay high while its enables are off

`timescale 1ns/1ps
`default_nettype none
`include "cdpo_cfg.svh"

module cdpo_driver (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [1:0] reg_be,
    input wire cdpo_pkg::cdpo_reg_t reg_wdata,
    output cdpo_pkg::cdpo_reg_t reg_rdata,
    output cdpo_pkg::cdpo_pins_t pulse_out,
    cdpo_if.device link
);

    typedef struct packed {
        // set half low, clear half high
        cdpo_pkg::cdpo_reg_t pulse_pin_enable_reg;

        // one level flop per pin
        cdpo_pkg::cdpo_pins_t pins;
    } cdpo_dst_t;

    // state after reset: all enables off, all pins low
    localparam cdpo_dst_t dst_reset = '{
        pulse_pin_enable_reg: `CDPO_REG_RESET,
        pins: '0
    };

    // registered state and its next value
    cdpo_dst_t s;

    cdpo_dst_t next_s;

    // set half and clear half of the control register
    cdpo_pkg::cdpo_pins_t set_enable_bits;

    cdpo_pkg::cdpo_pins_t clear_enable_bits;

    // compare events taken on this edge
    logic rise_event;

    logic fall_event;

    // per-pin decode of the events
    wire cdpo_pkg::cdpo_pins_t set_hit;

    wire cdpo_pkg::cdpo_pins_t clear_hit;

    wire cdpo_pkg::cdpo_pins_t pin_next;

    // per-lane write decode
    wire logic [`CDPO_LANE_COUNT-1:0] lane_wr;

    wire cdpo_pkg::cdpo_reg_t reg_next;

    assign set_enable_bits =
        s.pulse_pin_enable_reg[`CDPO_SET_LSB +: `CDPO_PIN_COUNT];

    assign clear_enable_bits =
        s.pulse_pin_enable_reg[`CDPO_CLR_LSB +: `CDPO_PIN_COUNT];

    assign rise_event = link.rise_match;

    assign fall_event = link.fall_match;

    // byte lanes are written on their own, at any time
    genvar lane;

    generate

        for (lane = 0; lane < `CDPO_LANE_COUNT; lane++) begin : g_lane

            logic lane_sel;

            logic [`CDPO_LANE_WIDTH-1:0] lane_old;

            logic [`CDPO_LANE_WIDTH-1:0] lane_new;

            logic [`CDPO_LANE_WIDTH-1:0] lane_val;

            // one byte enable per lane
            assign lane_sel = reg_be[lane];

            assign lane_wr[lane] = reg_wr & lane_sel;

            assign lane_old =
                s.pulse_pin_enable_reg[lane*`CDPO_LANE_WIDTH +: `CDPO_LANE_WIDTH];

            assign lane_new =
                reg_wdata[lane*`CDPO_LANE_WIDTH +: `CDPO_LANE_WIDTH];

            // keep the lane unless it is written
            always_comb begin
                unique case (lane_wr[lane])
                    1'b1: begin
                        lane_val = lane_new;
                    end

                    1'b0: begin
                        lane_val = lane_old;
                    end
                endcase
            end

            // merge the lane back into the word
            assign reg_next[lane*`CDPO_LANE_WIDTH +: `CDPO_LANE_WIDTH] =
                lane_val;

        end

    endgenerate

    // each pin follows its own pair of enables
    genvar pin;

    generate

        for (pin = 0; pin < `CDPO_PIN_COUNT; pin++) begin : g_pin

            logic set_en;

            logic clr_en;

            logic level;

            assign set_en = set_enable_bits[pin];

            assign clr_en = clear_enable_bits[pin];

            // a rise sets, a fall clears, each only where enabled
            assign set_hit[pin] = rise_event & set_en;

            assign clear_hit[pin] = fall_event & clr_en;

            always_comb begin
                unique case ({clear_hit[pin], set_hit[pin]})
                    2'b00: begin
                        level = s.pins[pin];
                    end

                    2'b01: begin
                        level = 1'b1;
                    end

                    2'b10: begin
                        level = 1'b0;
                    end

                    2'b11: begin
                        // low wins when both events meet
                        level = 1'b0;
                    end
                endcase
            end

            assign pin_next[pin] = level;

        end

    endgenerate

    // one register update and one pin update per edge
    always_comb begin
        next_s = s;

        next_s.pulse_pin_enable_reg = reg_next;

        // one event moves every enabled pin together
        next_s.pins = pin_next;

        // reset wins over everything
        if (!rst_n) begin
            next_s = dst_reset;
        end
    end

    // every register runs on every edge
    always_ff @(posedge clock) begin
        s <= next_s;
    end

    // outputs come straight from the state flops
    assign reg_rdata = s.pulse_pin_enable_reg;

    assign pulse_out = s.pins;

endmodule // cdpo_driver
`default_nettype wire

/* cdpo_properties.sv */
// checks of the pulse link
// assumes driver outputs wired in
`timescale 1ns/1ps
`default_nettype none
module cdpo_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rise_match,
    input wire logic fall_match,
    input wire cdpo_pkg::cdpo_reg_t reg_rdata,
    input wire cdpo_pkg::cdpo_pins_t pulse_out
);
    wire cdpo_pkg::cdpo_pins_t s = reg_rdata[7:0];
    wire cdpo_pkg::cdpo_pins_t c = reg_rdata[15:8];
    wire cdpo_pkg::cdpo_pins_t p = pulse_out;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence up; rise_match && !fall_match; endsequence
    sequence dn; fall_match && !rise_match; endsequence
    sequence both; rise_match && fall_match; endsequence
    rise_set_a: assert property (up |=> p == ($past(p) | $past(s))) else $error("rise");
    fall_clr_a: assert property (dn |=> p == ($past(p) & ~$past(c))) else $error("fall");
    both_low_a: assert property (both |=> p == (($past(p) | $past(s)) & ~$past(c)))
        else $error("both");
    idle_hold_a: assert property (!rise_match && !fall_match |=> $stable(p))
        else $error("hold");
    reset_zero_a: assert property (disable iff (1'b0) !rst_n |=> reg_rdata == 16'h0000 && p == 8'h00)
        else $error("reset");
    all_pins_a: assert property (rise_match && !fall_match && s == 8'hFF |=> &p)
        else $error("all pins");
    rise_cause_a: assert property ((p & ~$past(p)) != 8'h00 |-> $past(rise_match))
        else $error("rise cause");
    fall_cause_a: assert property ($past(rst_n) && (~p & $past(p)) != 8'h00 |-> $past(fall_match))
        else $error("fall cause");
endmodule // cdpo_properties
`default_nettype wire

/* compare_driven_pulse_outputs_tb.sv */
// bench: timer end drives the pulse driver end
// assumes cdpo_properties beside the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module compare_driven_pulse_outputs_tb;
    logic clock = 0;
    logic rst_n = 0;
    logic start = 0;
    logic rise_wr = 0;
    logic fall_wr = 0;
    logic reg_wr = 0;
    logic [1:0] reg_be = 2'h3;
    cdpo_pkg::cdpo_cnt_t wr_data = 16'h0000;
    cdpo_pkg::cdpo_reg_t reg_wdata = 16'h0000;
    cdpo_pkg::cdpo_cnt_t cnt;
    cdpo_pkg::cdpo_reg_t rdata;
    cdpo_pkg::cdpo_pins_t pins;
    int bad_count = 0;
    int n_compared = 0;
    cdpo_if link ();
    always #5 clock = ~clock;
    cdpo_timer cdpo_timer_inst (.clock(clock), .rst_n(rst_n), .start(start), .rise_wr(rise_wr),
        .fall_wr(fall_wr), .wr_data(wr_data), .count(cnt), .link(link));
    cdpo_driver cdpo_driver_inst (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .pulse_out(pins), .link(link));
    cdpo_properties cdpo_properties_inst (.clock(clock), .rst_n(rst_n), .reg_rdata(rdata),
        .rise_match(link.rise_match), .fall_match(link.fall_match), .pulse_out(pins));
    task automatic print_verdict();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // load enables and compares ahead of the count, then check pins
    task automatic arm(input logic a, input logic b, input cdpo_pkg::cdpo_reg_t en,
        input cdpo_pkg::cdpo_pins_t exp);
        cdpo_pkg::cdpo_cnt_t t;
        t = cnt + 16'h0020;
        reg_wr = 1;
        reg_wdata = en;
        rise_wr = a;
        fall_wr = b;
        wr_data = t;
        @(negedge clock);
        reg_wr = 0;
        rise_wr = 0;
        fall_wr = 0;
        start = 1;
        `CHK("enables", en, rdata)
        while (cnt != t + 16'h0004)
            @(negedge clock);
        `CHK("pins", exp, pins)
        t = cnt;
        @(negedge clock);
        `CHK("count runs", t + 16'h0001, cnt)
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1;
        `CHK("reset reg", 16'h0000, rdata)
        `CHK("reset pins", 8'h00, pins)
        arm(1, 0, 16'h0101, 8'h01);
        arm(1, 0, 16'h00FF, 8'hFF);
        arm(0, 1, 16'hE000, 8'h1F);
        arm(1, 1, 16'hFFFF, 8'h00);
        reg_be = 2'h2;
        reg_wdata = 16'h1234;
        reg_wr = 1;
        @(negedge clock);
        reg_wr = 0;
        `CHK("upper lane", 16'h12FF, rdata)
        reg_be = 2'h1;
        reg_wr = 1;
        @(negedge clock);
        reg_wr = 0;
        `CHK("lower lane", 16'h1234, rdata)
        rst_n = 0;
        @(negedge clock);
        rst_n = 1;
        `CHK("mid reset reg", 16'h0000, rdata)
        `CHK("mid reset pins", 8'h00, pins)
        `CHK("mid reset count", 16'h0000, cnt)
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        print_verdict();
    end
endmodule // compare_driven_pulse_outputs_tb
`default_nettype wire
